// ==== baud_tick_gen.sv ====
// bit-rate tick generator for one direction
`timescale 1ns/100ps
`include "uart_addr_cfg.svh"
module baud_tick_gen
  import uart_addr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] mode,
  input wire logic dbl,
  input wire logic use_tb,
  input wire logic six_clk,
  input wire logic t1_ovf,
  input wire logic [15:0] reload,
  output logic tick
);
  // a low reload stretches the timer-b bit time past 2^20 clocks, so the divider is 22 bits wide
  logic [21:0] cnt_r;
  logic [21:0] cnt_nxt;
  logic [5:0] t1_cnt_r;
  logic [5:0] t1_cnt_nxt;
  logic [21:0] period;
  logic [16:0] span;
  logic tick_c;
  logic t1_tick;
  always_comb begin
    period = 22'h000001;
    span = `RELOAD_TOP - {1'b0, reload};
    // shift mode ignores every timer source [R10]
    if (mode == 2'(MODE_SHIFT)) begin
      period = 22'(`DIV_SHIFT_MODE);
    end else if (mode == 2'(MODE_FIXED9)) begin
      period = dbl ? 22'(`DIV_FIXED_FAST) : 22'(`DIV_FIXED_SLOW); // [R11]
    end else if (use_tb) begin
      // 32 * (65536 - reload) / 2^dbl, halved again in six-clock mode [R13] [R15]
      period = {5'h00, span} << (3'h5 - {2'h0, dbl} - {2'h0, six_clk});
      if (period == 22'h000000) begin
        period = 22'h000001;
      end
    end
  end
  always_comb begin
    cnt_nxt = cnt_r + 22'h000001;
    tick_c = 1'b0;
    if (cnt_r + 22'h000001 >= period) begin
      cnt_nxt = 22'h000000;
      tick_c = 1'b1;
    end
    t1_cnt_nxt = t1_cnt_r;
    t1_tick = 1'b0;
    // timer 1 overflow in any of its running modes feeds the divider [R12] [R14]
    if (t1_ovf) begin
      t1_cnt_nxt = t1_cnt_r + 6'h01;
      if (t1_cnt_r + 6'h01 >= (dbl ? 6'h10 : 6'h20)) begin
        t1_cnt_nxt = 6'h00;
        t1_tick = 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_r <= 22'h000000;
      t1_cnt_r <= 6'h00;
    end else begin
      cnt_r <= cnt_nxt;
      t1_cnt_r <= t1_cnt_nxt;
    end
  end
  assign tick = (mode[0] && !use_tb) ? t1_tick : tick_c;
endmodule : baud_tick_gen

// ==== frame_partner.sv ====
// far-side sender model: received frames and timer 1 overflow pulses
`timescale 1ns/100ps
module frame_partner #(
  parameter int OVF_DIV = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req,
  input wire logic [7:0] req_data,
  input wire logic req_bit9,
  output logic frame_valid,
  output logic [7:0] frame_data,
  output logic frame_bit9,
  output logic timer1_ovf
);
  int cnt_r;
  always_ff @(posedge clk) begin
    frame_valid <= req && rst_b;
    // lines toggle outside a frame so stale data never passes for fresh
    frame_data <= req ? req_data : (rst_b ? ~frame_data : 8'h00);
    frame_bit9 <= req ? req_bit9 : (rst_b ? ~frame_bit9 : 1'b0);
    cnt_r <= (!rst_b || cnt_r == OVF_DIV - 1) ? 0 : cnt_r + 1;
    timer1_ovf <= rst_b && cnt_r == OVF_DIV - 1;
  end
endmodule : frame_partner

// ==== tb_uart_address_filter_baud.sv ====
// self-checking bench for the address filter and bit-rate block
`timescale 1ns/100ps
`include "uart_addr_cfg.svh"
module tb_uart_address_filter_baud
  import uart_addr_pkg::*;
;
  logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready, req, req_bit9;
  logic awready, wready, bvalid, arready, rvalid, fvalid, fbit9, t1ovf, txt, rxt, ninth, irq;
  logic [7:0] awaddr, araddr, req_data, fdata;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr, im;
  int n_fail, tests_run;

  uart_address_filter_baud u_dut (.CLK(clk), .RST_B(rst_b), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .FRAME_VALID(fvalid),
    .FRAME_DATA(fdata), .FRAME_BIT9(fbit9), .TIMER1_OVF(t1ovf), .TX_BAUD_TICK(txt),
    .RX_BAUD_TICK(rxt), .RX_NINTH_BIT(ninth), .IRQ(irq));
  frame_partner #(.OVF_DIV(4)) u_far (.clk(clk), .rst_b(rst_b), .req(req), .req_data(req_data),
    .req_bit9(req_bit9), .frame_valid(fvalid), .frame_data(fdata), .frame_bit9(fbit9), .timer1_ovf(t1ovf));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    chk("bresp", 32'h0, {30'h0, bresp});
  endtask : axw

  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rd = rdata;
    rr = rresp;
  endtask : axr

  // the done flag blocks later frames, so every frame is cleared after checking
  task automatic frm(input logic [7:0] d, input logic b9, input logic [1:0] st);
    req <= 1'b1;
    req_data <= d;
    req_bit9 <= b9;
    @(posedge clk);
    req <= 1'b0;
    repeat (3) @(posedge clk);
    axr(`OFF_STATUS);
    chk("status", {30'h0, st}, rd);
    chk("irq", {31'h0, |(st & im)}, {31'h0, irq});
    axw(`OFF_STATUS, 32'h3);
    @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
  endtask : frm

  task automatic tk(input string nm, input logic rx, input int exp);
    int c, k;
    c = 0;
    k = 0;
    while (k < 3 && c < 5000) begin
      @(posedge clk);
      c++;
      if (rx ? rxt : txt) begin
        k++;
        if (k == 2) c = 0;
      end
    end
    chk(nm, exp, c);
  endtask : tk

  task automatic t_regs;
    axr(`OFF_OWN_ADDR);
    chk("own addr", 32'h0, rd);
    axr(`OFF_ADDR_MASK);
    chk("addr mask", 32'h0, rd);
    axr(`OFF_RELOAD);
    chk("reload", 32'h0000FFFF, rd);
    axr(8'h1C);
    chk("unmapped resp", 32'h2, {30'h0, rr});
    chk("unmapped data", 32'h0, rd);
    $display("test regs done");
  endtask : t_regs

  task automatic t_filter;
    axw(`OFF_CTRL, 32'h7);
    axw(`OFF_IRQ_MASK, 32'h1);
    im = 2'h1;
    frm(8'h5A, 1'b1, 2'h1);
    axr(`OFF_RX_DATA);
    chk("rx data", 32'h0000015A, rd);
    chk("ninth bit", 32'h1, {31'h0, ninth});
    frm(8'h5A, 1'b0, 2'h2);
    axw(`OFF_IRQ_MASK, 32'h2);
    im = 2'h2;
    axw(`OFF_OWN_ADDR, 32'hC0);
    axw(`OFF_ADDR_MASK, 32'hFD);
    frm(8'hC2, 1'b1, 2'h1);
    frm(8'hC1, 1'b1, 2'h2);
    frm(8'hFD, 1'b1, 2'h1);
    axw(`OFF_CTRL, 32'h5);
    frm(8'hC2, 1'b0, 2'h2);
    frm(8'hC2, 1'b1, 2'h1);
    frm(8'hC1, 1'b1, 2'h2);
    axw(`OFF_CTRL, 32'h4);
    frm(8'hC1, 1'b0, 2'h1);
    $display("test filter done");
  endtask : t_filter

  task automatic t_baud;
    axw(`OFF_CTRL, 32'h0);
    tk("shift rate", 1'b1, 12);
    axw(`OFF_CTRL, 32'h2);
    tk("fixed slow", 1'b1, 64);
    axw(`OFF_CTRL, 32'hA);
    tk("fixed fast", 1'b1, 32);
    axw(`OFF_CTRL, 32'h3);
    tk("timer1", 1'b1, 128);
    axw(`OFF_CTRL, 32'hB);
    tk("timer1 dbl", 1'b1, 64);
    axw(`OFF_CTRL, 32'h23);
    tk("tb rx", 1'b1, 32);
    axw(`OFF_CTRL, 32'h13);
    tk("tb tx", 1'b0, 32);
    axw(`OFF_CTRL, 32'h1B);
    tk("tb tx dbl", 1'b0, 16);
    axw(`OFF_RELOAD, 32'h0000FFFE);
    axw(`OFF_CTRL, 32'h23);
    tk("tb reload", 1'b1, 64);
    axw(`OFF_CTRL, 32'h63);
    tk("tb six clk", 1'b1, 32);
    $display("test baud done");
  endtask : t_baud

  // a second reset mid-run must wipe the addresses that the filter test left behind
  task automatic t_reset;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    axr(`OFF_OWN_ADDR);
    chk("own addr after reset", 32'h0, rd);
    axr(`OFF_ADDR_MASK);
    chk("addr mask after reset", 32'h0, rd);
    $display("test reset done");
  endtask : t_reset

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  initial begin
    rst_b = 1'b0;
    {awvalid, wvalid, arvalid, req, req_bit9} = 5'h00;
    {awaddr, araddr, req_data, wdata} = 56'h0;
    {bready, rready, wstrb, im} = 8'hFC;
    n_fail = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs;
    t_filter;
    t_baud;
    t_reset;
    give_verdict;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict;
  end
endmodule : tb_uart_address_filter_baud

// ==== uart_addr_cfg.svh ====
// constants for the address filter and bit-rate block
`ifndef UART_ADDR_CFG_SVH
`define UART_ADDR_CFG_SVH
`define OFF_CTRL 8'h00
`define OFF_OWN_ADDR 8'h04
`define OFF_ADDR_MASK 8'h08
`define OFF_STATUS 8'h0C
`define OFF_IRQ_MASK 8'h10
`define OFF_RX_DATA 8'h14
`define OFF_RELOAD 8'h18
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 1
`define CTRL_FILTER 2
`define CTRL_DOUBLE 3
`define CTRL_TX_TB 4
`define CTRL_RX_TB 5
`define CTRL_SIX_CLK 6
`define ST_RX_DONE 0
`define ST_DROPPED 1
`define RST_OWN_ADDR 8'h00
`define RST_ADDR_MASK 8'h00
`define RST_RELOAD 16'hFFFF
`define DIV_SHIFT_MODE 12
`define DIV_FIXED_SLOW 64
`define DIV_FIXED_FAST 32
`define DIV_VAR 32
`define RELOAD_TOP 17'h10000
`endif

// ==== uart_addr_pkg.sv ====
// types shared by the address filter and bit-rate block
package uart_addr_pkg;
  typedef enum logic [1:0] {
    MODE_SHIFT,
    MODE_VAR8,
    MODE_FIXED9,
    MODE_VAR9
  } uart_mode_e;
endpackage : uart_addr_pkg

// ==== uart_address_filter_baud.sv ====
// serial receive address filter, frame flagging and bit-rate selection
// What this block does
// [R1] 9-bit modes capture nine bits; ninth bit goes to rx_ninth_bit.
// [R2] filter on in 9-bit mode: receive interrupt only when ninth bit is 1.
// [R3] far master sends ninth bit 1 for address, 0 for data.
// [R4] filter enable has no effect in shift-register mode.
// [R5] 9-bit filter: done flag needs ninth bit 1 and given or broadcast match.
// [R6] 8-bit filter: done flag needs valid stop bit and address match.
// [R7] given match compares only bits where mask bit is one.
// [R8] broadcast is own address OR mask; its one bits must match.
// [R9] reset clears own address and mask, so every address matches.
// [R10] shift mode rate is system clock over 12.
// [R11] fixed 9-bit rate is clock over 64, or 32 when doubled.
// [R12] variable modes use timer overflow times 2^doubling over 32.
// [R13] timer-b select: rate is 2^dbl clock over 32*(65536-reload).
// [R14] timer 1 overflow in any mode serves as rate source.
// [R15] six-clock mode doubles the timer-b rate.
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "uart_addr_cfg.svh"
module uart_address_filter_baud
  import uart_addr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic FRAME_VALID,
  input wire logic [7:0] FRAME_DATA,
  input wire logic FRAME_BIT9,
  input wire logic TIMER1_OVF,
  output logic TX_BAUD_TICK,
  output logic RX_BAUD_TICK,
  output logic RX_NINTH_BIT,
  output logic IRQ
);
  // frame inputs come from the receive shifter on CLK; FRAME_BIT9 is ninth bit or stop bit
  logic [6:0] ctrl_r, ctrl_nxt;
  logic [7:0] own_r, own_nxt;
  logic [7:0] mask_r, mask_nxt;
  logic [1:0] stat_r, stat_nxt;
  logic [1:0] imask_r, imask_nxt;
  logic [7:0] rxd_r, rxd_nxt;
  logic ninth_r, ninth_nxt;
  logic [15:0] reload_r, reload_nxt;
  logic aw_held_r, aw_held_nxt;
  logic w_held_r, w_held_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [1:0] mode;
  logic filt;
  logic given_hit, bcast_hit, addr_hit, accept;
  logic [7:0] bcast;
  logic do_wr, wr_ok;
  logic [7:0] wa;
  logic [31:0] wd;

  assign mode = ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO];
  assign filt = ctrl_r[`CTRL_FILTER];
  assign given_hit = ((FRAME_DATA ^ own_r) & mask_r) == 8'h00; // [R7]
  assign bcast = own_r | mask_r; // [R8]
  assign bcast_hit = (FRAME_DATA & bcast) == bcast; // [R8]
  assign addr_hit = given_hit | bcast_hit;

  always_comb begin
    accept = 1'b1;
    if (stat_r[`ST_RX_DONE]) begin
      accept = 1'b0;
    end else if (!filt || mode == 2'(MODE_SHIFT)) begin
      accept = 1'b1; // [R4]
    end else if (mode == 2'(MODE_VAR8)) begin
      accept = FRAME_BIT9 && addr_hit; // [R6]
    end else begin
      accept = FRAME_BIT9 && addr_hit; // [R2] [R5]
    end
  end

  // write channel: address and data may arrive in either order
  assign AWREADY = !aw_held_r && !bvalid_r;
  assign WREADY = !w_held_r && !bvalid_r;
  assign ARREADY = !rvalid_r;
  assign wa = aw_held_r ? awaddr_r : AWADDR;
  assign wd = w_held_r ? wdata_r : WDATA;
  assign do_wr = (aw_held_r || (AWVALID && AWREADY)) && (w_held_r || (WVALID && WREADY));
  always_comb begin
    wr_ok = 1'b1;
    unique case (wa)
      `OFF_CTRL, `OFF_OWN_ADDR, `OFF_ADDR_MASK, `OFF_STATUS, `OFF_IRQ_MASK, `OFF_RELOAD: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    own_nxt = own_r;
    mask_nxt = mask_r;
    imask_nxt = imask_r;
    reload_nxt = reload_r;
    stat_nxt = stat_r;
    rxd_nxt = rxd_r;
    ninth_nxt = ninth_r;
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (AWVALID && AWREADY) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt = AWADDR;
    end
    if (WVALID && WREADY) begin
      w_held_nxt = 1'b1;
      wdata_nxt = WDATA;
      wstrb_nxt = WSTRB;
    end
    if (do_wr) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_ok ? 2'h0 : 2'h2;
      if ((w_held_r ? wstrb_r[0] : WSTRB[0]) && wr_ok) begin
        unique case (wa)
          `OFF_CTRL: ctrl_nxt = wd[6:0];
          `OFF_OWN_ADDR: own_nxt = wd[7:0];
          `OFF_ADDR_MASK: mask_nxt = wd[7:0];
          `OFF_STATUS: stat_nxt = stat_r & ~wd[1:0];
          `OFF_IRQ_MASK: imask_nxt = wd[1:0];
          `OFF_RELOAD: reload_nxt[7:0] = wd[7:0];
          default: ctrl_nxt = ctrl_r;
        endcase
      end
      if ((w_held_r ? wstrb_r[1] : WSTRB[1]) && wa == `OFF_RELOAD) begin
        reload_nxt[15:8] = wd[15:8];
      end
    end else if (bvalid_r && BREADY) begin
      bvalid_nxt = 1'b0;
    end
    // a frame event wins over a same-cycle software clear
    if (FRAME_VALID) begin
      if (accept) begin
        rxd_nxt = FRAME_DATA;
        ninth_nxt = FRAME_BIT9; // [R1]
        stat_nxt[`ST_RX_DONE] = 1'b1; // [R2] [R5] [R6]
      end else begin
        stat_nxt[`ST_DROPPED] = 1'b1;
      end
    end
    if (ARVALID && ARREADY) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = 2'h0;
      unique case (ARADDR)
        `OFF_CTRL: rdata_nxt = {25'h0, ctrl_r};
        `OFF_OWN_ADDR: rdata_nxt = {24'h0, own_r};
        `OFF_ADDR_MASK: rdata_nxt = {24'h0, mask_r};
        `OFF_STATUS: rdata_nxt = {30'h0, stat_r};
        `OFF_IRQ_MASK: rdata_nxt = {30'h0, imask_r};
        `OFF_RX_DATA: rdata_nxt = {23'h0, ninth_r, rxd_r};
        `OFF_RELOAD: rdata_nxt = {16'h0, reload_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = 2'h2;
        end
      endcase
    end else if (rvalid_r && RREADY) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ctrl_r <= 7'h00;
      own_r <= `RST_OWN_ADDR; // [R9]
      mask_r <= `RST_ADDR_MASK; // [R9]
      stat_r <= 2'h0;
      imask_r <= 2'h0;
      rxd_r <= 8'h00;
      ninth_r <= 1'b0;
      reload_r <= `RST_RELOAD;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      own_r <= own_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
      imask_r <= imask_nxt;
      rxd_r <= rxd_nxt;
      ninth_r <= ninth_nxt;
      reload_r <= reload_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign RVALID = rvalid_r;
  assign RDATA = rdata_r;
  assign RRESP = rresp_r;
  assign RX_NINTH_BIT = ninth_r;
  assign IRQ = |(stat_r & imask_r);

  // both directions share mode and doubling; each picks its own source
  baud_tick_gen u_tx_rate (
    .clk(CLK),
    .rst_b(RST_B),
    .mode(mode),
    .dbl(ctrl_r[`CTRL_DOUBLE]),
    .use_tb(ctrl_r[`CTRL_TX_TB]),
    .six_clk(ctrl_r[`CTRL_SIX_CLK]),
    .t1_ovf(TIMER1_OVF),
    .reload(reload_r),
    .tick(TX_BAUD_TICK)
  );
  baud_tick_gen u_rx_rate (
    .clk(CLK),
    .rst_b(RST_B),
    .mode(mode),
    .dbl(ctrl_r[`CTRL_DOUBLE]),
    .use_tb(ctrl_r[`CTRL_RX_TB]),
    .six_clk(ctrl_r[`CTRL_SIX_CLK]),
    .t1_ovf(TIMER1_OVF),
    .reload(reload_r),
    .tick(RX_BAUD_TICK)
  );

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // a frame only counts against a clear done flag; a held flag keeps the buffer for software
  nine_drop_a: assert property ( // [R2]
    FRAME_VALID && filt && mode[1] && !FRAME_BIT9 |=> $stable(stat_r[`ST_RX_DONE]))
    else $error("data frame set done flag under filter");
  nine_keep_a: assert property ( // [R1]
    FRAME_VALID && accept && mode[1] |=> ninth_r == $past(FRAME_BIT9))
    else $error("ninth bit not captured");
  shift_free_a: assert property ( // [R4]
    FRAME_VALID && !stat_r[0] && mode == 2'(MODE_SHIFT) |=> stat_r[0])
    else $error("filter affected shift mode");
  addr_miss_a: assert property ( // [R5]
    FRAME_VALID && filt && mode != 2'(MODE_SHIFT) && !given_hit && !bcast_hit && !stat_r[0] |=> !stat_r[0])
    else $error("unmatched address accepted");
  stop_bad_a: assert property ( // [R6]
    FRAME_VALID && filt && mode == 2'(MODE_VAR8) && !FRAME_BIT9 && !stat_r[0] |=> !stat_r[0])
    else $error("bad stop bit accepted");
  stop_good_a: assert property ( // [R6]
    FRAME_VALID && filt && mode == 2'(MODE_VAR8) && FRAME_BIT9 && addr_hit && !stat_r[0] |=> stat_r[0])
    else $error("valid addressed frame lost");
  given_take_a: assert property ( // [R5]
    FRAME_VALID && filt && mode[1] && FRAME_BIT9 && given_hit && !stat_r[0] |=> stat_r[0])
    else $error("given address frame lost");
  given_mask_a: assert property ( // [R7]
    mask_r == 8'h00 |-> given_hit)
    else $error("empty mask must match everything");
  bcast_all_a: assert property ( // [R8]
    (own_r | mask_r) == 8'hFF |-> bcast_hit == (FRAME_DATA == 8'hFF))
    else $error("broadcast compare wrong");
  bcast_take_a: assert property ( // [R8]
    FRAME_VALID && filt && mode[1] && FRAME_BIT9 && bcast_hit && !stat_r[0] |=> stat_r[0])
    else $error("broadcast frame lost");
  reset_addr_a: assert property ( // [R9]
    $rose(RST_B) |-> own_r == 8'h00 && mask_r == 8'h00)
    else $error("address registers not cleared");
  open_take_a: assert property ( // [R9]
    FRAME_VALID && own_r == 8'h00 && mask_r == 8'h00 && FRAME_BIT9 && !stat_r[0] |=> stat_r[0])
    else $error("cleared address filter dropped a frame");
  data_keep_a: assert property ( // [R1]
    FRAME_VALID && accept |=> rxd_r == $past(FRAME_DATA))
    else $error("received byte not stored");
  done_block_a: assert property (
    FRAME_VALID && stat_r[`ST_RX_DONE] |=> $stable(rxd_r) && $stable(ninth_r))
    else $error("frame overwrote unread data");
  drop_mark_a: assert property (
    FRAME_VALID && !accept |=> stat_r[`ST_DROPPED])
    else $error("dropped frame not flagged");
  shift_pace_a: assert property ( // [R10]
    RX_BAUD_TICK && mode == 2'(MODE_SHIFT) |=> !RX_BAUD_TICK || $changed(ctrl_r))
    else $error("shift mode ticks too fast");
  fixed_pace_a: assert property ( // [R11]
    TX_BAUD_TICK && mode == 2'(MODE_FIXED9) |=> !TX_BAUD_TICK || $changed(ctrl_r))
    else $error("fixed rate ticks too fast");
  write_ans_a: assert property (
    do_wr |=> BVALID)
    else $error("write not answered");
  resp_hold_a: assert property (
    BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  read_ans_a: assert property (
    ARVALID && ARREADY |=> RVALID)
    else $error("read not answered");
  read_hold_a: assert property (
    RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
    else $error("read data dropped early");
  bad_addr_a: assert property (
    ARVALID && ARREADY && ARADDR > `OFF_RELOAD |=> RRESP == 2'h2 && RDATA == 32'h0000_0000)
    else $error("unmapped read not refused");
  irq_level_a: assert property (
    FRAME_VALID && accept && imask_r[`ST_RX_DONE] && !do_wr |=> IRQ)
    else $error("irq missed accepted frame");
endmodule : uart_address_filter_baud
